// ==== design/dram_host_ctrl.sv ====
`timescale 1ns/1ps
`include "dram_host_params.svh"

module dram_host_ctrl
  import dram_host_pkg::*;
#(
  parameter int P_RASP_CYC = `T_RASP_MAX_CYC, // page row-low limit in cycles
  parameter int P_REF_WINDOW_CYC = `REF_WINDOW_CYC // full refresh window in cycles
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [`REQ_ADDR_W-1:0] i_req_addr,
  input wire logic [`DATA_W-1:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [`DATA_W-1:0] o_rd_data,
  input wire logic i_ras_only_refresh,
  output logic o_row_strobe_n,
  output logic o_col_strobe_n,
  output logic o_write_strobe_n,
  output logic [`ADDR_W-1:0] o_muxed_address_lines,
  input wire logic [`DATA_W-1:0] i_shared_data_lines,
  output logic [`DATA_W-1:0] o_shared_data_lines,
  output logic o_shared_data_lines_oe
);

  // ----------------------------------------------------------------
  // cycle counts
  // ----------------------------------------------------------------
  // column strobe low long enough for row and column access times
  localparam int CAS_LOW_CYC = `T_RAC_CYC;
  // one column step: address, strobe low, strobe high
  localparam int PAGE_STEP_CYC = CAS_LOW_CYC + 2;
  // short refresh rows must still fill the random cycle time
  localparam int PRE_CYC = (`T_RC_CYC - `T_RAS_CYC > `T_RP_CYC) ?
    (`T_RC_CYC - `T_RAS_CYC) : `T_RP_CYC;
  localparam int REF_STEP_CYC = P_REF_WINDOW_CYC / `REF_ROWS;
  localparam int OPEN_LIMIT = P_RASP_CYC - 2 * PAGE_STEP_CYC;

  localparam ctrl_t RST_VAL = '{st: ST_PRE, cnt: 8'(PRE_CYC - 1),
    ras_n: `STROBE_IDLE, cas_n: `STROBE_IDLE, we_n: `STROBE_IDLE, default: '0};

  ctrl_t r; // registered state
  ctrl_t n; // next state
  logic ref_tick; // refresh timer expired
  logic open_load; // row strobe falls for an access
  logic open_done; // page window nearly used up
  logic page_ok; // next request may reuse the open row

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // free-running refresh pacing; reloads itself on expiry
  cycle_timer #(.W(`REF_TMR_W)) u_ref_tmr (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_load(ref_tick),
    .i_value(`REF_TMR_W'(REF_STEP_CYC - 1)),
    .o_done(ref_tick)
  );

  // bounds how long an open row may stay open in page mode
  cycle_timer #(.W(`OPEN_W)) u_open_tmr (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_load(open_load),
    .i_value(`OPEN_W'(OPEN_LIMIT)),
    .o_done(open_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.rd_valid = 1'b0;
    o_req_ready = 1'b0;
    open_load = 1'b0;
    page_ok = i_req_valid && !r.ref_pend && !open_done &&
      (i_req_addr[`REQ_ADDR_W-1:`ROW_LSB] == r.row);
    case (r.st)
      // row strobe high for precharge and cycle time
      ST_PRE: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else begin
          n.st = ST_IDLE;
        end
      end
      // refresh outranks new requests
      ST_IDLE: begin
        if (r.ref_pend) begin
          n.ref_pend = 1'b0;
          n.rev_ref = !i_ras_only_refresh;
          if (!i_ras_only_refresh) begin
            n.cas_n = 1'b0;
            n.we_n = 1'b1;
            n.cnt = 8'(`T_CSR_CYC - 1);
            n.st = ST_REF_CAS;
          end else begin
            n.ras_n = 1'b0;
            n.addr = {1'b0, r.ref_row};
            n.ref_row = r.ref_row + `REF_ROW_W'(1);
            n.cnt = 8'(`T_RAS_CYC - 1);
            n.st = ST_REF_RAS;
          end
        end else if (i_req_valid) begin
          o_req_ready = 1'b1;
          open_load = 1'b1;
          n.row = i_req_addr[`REQ_ADDR_W-1:`ROW_LSB];
          n.col = i_req_addr[`ROW_LSB-1:0];
          n.wr = i_req_write;
          n.wdata = i_req_wdata;
          n.ras_n = 1'b0;
          n.addr = i_req_addr[`REQ_ADDR_W-1:`ROW_LSB];
          n.cnt = 8'(`T_RCD_CYC - 1);
          n.st = ST_ROW;
        end
      end
      // row address held while row strobe settles
      ST_ROW: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else begin
          n.addr = r.col;
          n.we_n = !r.wr;
          n.dq_oe = r.wr;
          n.st = ST_COLADR;
        end
      end
      // column address and write strobe settle before column falls
      ST_COLADR: begin
        n.cas_n = 1'b0;
        n.cnt = 8'(CAS_LOW_CYC - 1);
        n.st = ST_CASLO;
      end
      // data is sampled on the last low cycle of the column strobe
      ST_CASLO: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else begin
          if (!r.wr) begin
            n.rd_valid = 1'b1;
            n.rd_data = i_shared_data_lines;
          end
          n.cas_n = 1'b1;
          n.st = ST_CASUP;
        end
      end
      // write strobe and data are released only after column rises
      ST_CASUP: begin
        n.we_n = 1'b1;
        n.dq_oe = 1'b0;
        if (page_ok) begin
          o_req_ready = 1'b1;
          n.col = i_req_addr[`ROW_LSB-1:0];
          n.wr = i_req_write;
          n.wdata = i_req_wdata;
          n.addr = i_req_addr[`ROW_LSB-1:0];
          n.we_n = !i_req_write;
          n.dq_oe = i_req_write;
          n.st = ST_COLADR;
        end else begin
          n.ras_n = 1'b1;
          n.cnt = 8'(PRE_CYC - 1);
          n.st = ST_PRE;
        end
      end
      // column strobe already low; now drop the row strobe
      ST_REF_CAS: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else begin
          n.ras_n = 1'b0;
          n.cnt = 8'(`T_RAS_CYC - 1);
          n.st = ST_REF_RAS;
        end
      end
      // refresh row strobe pulse; in a reversed refresh both strobes rise together
      ST_REF_RAS: begin
        if (r.cnt != 8'h00) begin
          n.cnt = r.cnt - 8'h01;
        end else begin
          n.ras_n = 1'b1;
          n.cas_n = 1'b1;
          n.cnt = 8'(PRE_CYC - 1);
          n.st = ST_PRE;
        end
      end
      default: begin
        n = RST_VAL;
      end
    endcase
    // a tick in the cycle that takes the refresh wins over the clear
    if (ref_tick) begin
      n.ref_pend = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign o_rd_valid = r.rd_valid;
  assign o_rd_data = r.rd_data;
  assign o_row_strobe_n = r.ras_n;
  assign o_col_strobe_n = r.cas_n;
  assign o_write_strobe_n = r.we_n;
  assign o_muxed_address_lines = r.addr;
  assign o_shared_data_lines = r.wdata;
  assign o_shared_data_lines_oe = r.dq_oe;

  // ----------------------------------------------------------------
  // checks on the strobes this controller drives
  // ----------------------------------------------------------------
  localparam int REF_WAIT_MAX = 30;
  logic [16:0] ras_low_cnt; // cycles the row strobe has been low
  logic [7:0] ras_high_cnt; // cycles the row strobe has been high
  logic [7:0] ras_gap; // cycles since last row strobe fall
  logic [7:0] cas_gap; // cycles since last column strobe fall
  logic ras_prev; // row strobe one cycle ago
  logic cas_prev; // column strobe one cycle ago
  logic fall_in_row; // one column fall already in this row
  logic page_seen; // a second column fall in this row

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ras_low_cnt <= '0;
      ras_high_cnt <= 8'hff;
      ras_gap <= 8'hff;
      cas_gap <= 8'hff;
      ras_prev <= 1'b1;
      cas_prev <= 1'b1;
      fall_in_row <= 1'b0;
      page_seen <= 1'b0;
    end else begin
      ras_prev <= o_row_strobe_n;
      cas_prev <= o_col_strobe_n;
      ras_low_cnt <= o_row_strobe_n ? 17'h00000 : ras_low_cnt + 17'h00001;
      ras_high_cnt <= !o_row_strobe_n ? 8'h00 :
        (ras_high_cnt == 8'hff ? 8'hff : ras_high_cnt + 8'h01);
      ras_gap <= (ras_prev && !o_row_strobe_n) ? 8'h01 :
        (ras_gap == 8'hff ? 8'hff : ras_gap + 8'h01);
      cas_gap <= (cas_prev && !o_col_strobe_n) ? 8'h01 :
        (cas_gap == 8'hff ? 8'hff : cas_gap + 8'h01);
      if (o_row_strobe_n) begin
        fall_in_row <= 1'b0;
        page_seen <= 1'b0;
      end else if (cas_prev && !o_col_strobe_n) begin
        fall_in_row <= 1'b1;
        page_seen <= fall_in_row;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_rev_start;
    $fell(o_row_strobe_n) && !o_col_strobe_n;
  endsequence

  sequence s_read_cas;
    $fell(o_col_strobe_n) && o_write_strobe_n;
  endsequence

  AST_REF_PROMPT: assert property ($rose(r.ref_pend) |->
    ##[1:REF_WAIT_MAX] (r.st == ST_REF_CAS || r.st == ST_REF_RAS))
    else $error("refresh not started in time");
  AST_EARLY_WRITE: assert property (
    $fell(o_col_strobe_n) && !o_write_strobe_n |-> !$past(o_write_strobe_n))
    else $error("write strobe not low before column strobe");
  AST_ROW_ADDR: assert property (
    $fell(o_row_strobe_n) && r.st == ST_ROW |-> o_muxed_address_lines == r.row ##1 o_col_strobe_n)
    else $error("row address wrong at row strobe fall");
  AST_COL_ADDR: assert property (
    $fell(o_col_strobe_n) && r.st == ST_CASLO |-> $stable(o_muxed_address_lines))
    else $error("column address not set up before column strobe");
  AST_REV_ORDER: assert property (s_rev_start |-> !$past(o_col_strobe_n))
    else $error("column strobe not low before row strobe");
  AST_RAS_ONLY: assert property (r.st == ST_REF_RAS && !r.rev_ref |-> o_col_strobe_n)
    else $error("column strobe low in row-only refresh");
  AST_REV_WE_HIGH: assert property (
    s_rev_start |-> $past(o_write_strobe_n) && o_write_strobe_n ##1 o_write_strobe_n)
    else $error("write strobe low around reversed refresh");
  AST_NONPAGE_MAX: assert property (
    !o_row_strobe_n && !page_seen |-> ras_low_cnt < 17'(`T_RAS_MAX_CYC))
    else $error("row strobe low too long");
  AST_PAGE_MAX: assert property (!o_row_strobe_n |-> ras_low_cnt < 17'(P_RASP_CYC))
    else $error("page row strobe low too long");
  AST_PAGE_SPACING: assert property ($fell(o_col_strobe_n) |-> cas_gap >= 8'(`T_PC_CYC))
    else $error("column cycles too close");
  AST_CYCLE_TIME: assert property ($fell(o_row_strobe_n) |-> ras_gap >= 8'(`T_RC_CYC))
    else $error("random cycles too close");
  AST_PRECHARGE: assert property (
    $fell(o_row_strobe_n) |-> ras_high_cnt >= 8'(`T_RP_CYC))
    else $error("precharge too short");
  AST_READ_WE_HIGH: assert property (s_read_cas |-> o_write_strobe_n [*4])
    else $error("write strobe dropped during read");

endmodule

// ==== inc/dram_host_params.svh ====
`ifndef DRAM_HOST_PARAMS_SVH
`define DRAM_HOST_PARAMS_SVH

// ----------------------------------------------------------------
// clock and cycle conversion
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 20
// least times round up, longest times round down
`define CYC_CEIL(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_FLOOR(ns) (((ns) / `CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `CLK_PERIOD_NS))

// ----------------------------------------------------------------
// strobe timing of the fastest grade, in ns; refresh period in ms and refresh row count
// ----------------------------------------------------------------
`define T_RC_NS 110
`define T_PC_NS 40
`define T_RP_NS 40
`define T_RAS_MIN_NS 60
`define T_RAS_MAX_NS 10000
`define T_RASP_MAX_NS 100000
`define T_RAC_NS 60
`define T_RCD_NS 20
`define T_RAH_NS 10
`define T_CSR_NS 10
`define T_CHR_NS 15
`define T_REF_MS 16
`define REF_ROWS 1024

// ----------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------
`define T_RC_CYC `CYC_CEIL(`T_RC_NS)
`define T_PC_CYC `CYC_CEIL(`T_PC_NS)
`define T_RP_CYC `CYC_CEIL(`T_RP_NS)
`define T_RAS_CYC `CYC_CEIL(`T_RAS_MIN_NS)
`define T_RAS_MAX_CYC `CYC_FLOOR(`T_RAS_MAX_NS)
`define T_RASP_MAX_CYC `CYC_FLOOR(`T_RASP_MAX_NS)
`define T_RAC_CYC `CYC_CEIL(`T_RAC_NS)
`define T_RCD_CYC `CYC_CEIL(`T_RCD_NS)
`define T_CSR_CYC `CYC_CEIL(`T_CSR_NS)
`define REF_WINDOW_CYC ((`T_REF_MS * 1000000) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// widths and field positions
// ----------------------------------------------------------------
`define ADDR_W 11
`define DATA_W 8
`define REQ_ADDR_W 22
`define ROW_LSB 11
`define REF_ROW_W 10
`define OPEN_W 17
`define REF_TMR_W 20
`define STROBE_IDLE 1'b1

`endif

// ==== inc/dram_host_pkg.sv ====
`include "dram_host_params.svh"

package dram_host_pkg;

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_PRE,
    ST_IDLE,
    ST_ROW,
    ST_COLADR,
    ST_CASLO,
    ST_CASUP,
    ST_REF_CAS,
    ST_REF_RAS
  } state_t;

  // ----------------------------------------------------------------
  // whole controller state
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t st;
    logic [7:0] cnt;
    logic ref_pend;
    logic rev_ref;
    logic [`ADDR_W-1:0] row;
    logic [`ADDR_W-1:0] col;
    logic wr;
    logic [`DATA_W-1:0] wdata;
    logic [`REF_ROW_W-1:0] ref_row;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`ADDR_W-1:0] addr;
    logic dq_oe;
    logic rd_valid;
    logic [`DATA_W-1:0] rd_data;
  } ctrl_t;

endpackage

// ==== design/cycle_timer.sv ====
`timescale 1ns/1ps

// down counter; done while the count stands at zero
module cycle_timer #(
  parameter int W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  output logic o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_t;

  tmr_t r; // registered state
  tmr_t n; // next state

  // ----------------------------------------------------------------
  // next count
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    if (i_load) begin
      n.cnt = i_value;
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - W'(1);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign o_done = (r.cnt == '0);

endmodule

// ==== testbench/dram_module_model.sv ====
`timescale 1ns/1ps
`include "dram_host_params.svh"

// behavioural model of the byte-wide memory module on the far side of the strobes
module dram_module_model #(
  parameter int P_FAST_NS = 5, // prompt data after column fall
  parameter int P_SLOW_NS = 50, // late data, still inside the three-cycle column low
  parameter int P_PAGE_MAX_NS = 100000 // page row-low ceiling
) (
  input wire logic i_row_strobe_n,
  input wire logic i_col_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic [`ADDR_W-1:0] i_muxed_address_lines,
  input wire logic [`DATA_W-1:0] i_shared_data_lines,
  input wire logic i_host_oe,
  input wire logic i_slow,
  output logic [`DATA_W-1:0] o_shared_data_lines,
  output int o_rev_count,
  output int o_row_count,
  output int o_violations
);
  // ------------------------------------------------------------
  // storage and strobe history
  // ------------------------------------------------------------
  logic [`DATA_W-1:0] mem [bit [21:0]]; // sparse byte store
  logic [`ADDR_W-1:0] row_q; // row latched at row fall
  logic [21:0] key; // row and column of the access
  logic rev_q; // current row cycle is a reversed refresh
  logic rd_q; // column low in a read
  logic ras_low; // row strobe seen low
  logic drive; // model owns the data lines
  int cas_in_row; // column cycles in the open row
  realtime ras_fall;
  realtime ras_rise;
  realtime cas_fall;

  initial begin
    o_shared_data_lines = 8'h00;
    o_rev_count = 0;
    o_row_count = 0;
    o_violations = 0;
    ras_fall = -1000;
    ras_rise = -1000;
    cas_fall = -1000;
    ras_low = 1'b0;
    drive = 1'b0;
    rd_q = 1'b0;
    cas_in_row = 0;
  end

  task automatic flag(input string what);
    o_violations++;
    $display("Error %s expected legal timing seen violation", what);
  endtask

  // ------------------------------------------------------------
  // row strobe edges
  // ------------------------------------------------------------
  always @(negedge i_row_strobe_n) begin
    if ($realtime - ras_rise < `T_RP_NS) flag("precharge");
    if ($realtime - ras_fall < `T_RC_NS) flag("row cycle");
    ras_fall = $realtime;
    ras_low = 1'b1;
    cas_in_row = 0;
    rev_q = (i_col_strobe_n === 1'b0);
    if (rev_q && i_write_strobe_n !== 1'b1) flag("write strobe in reversed refresh");
    if (rev_q) begin
      o_rev_count++;
    end else begin
      // address lines change in the same step as the strobe; let them settle
      #1;
      row_q = i_muxed_address_lines;
    end
  end

  // row rise closes the cycle; a row cycle with no column is a refresh
  always @(posedge i_row_strobe_n) begin
    if (ras_low) begin
      if (!rev_q && cas_in_row == 0) o_row_count++;
      if (cas_in_row > 1 && $realtime - ras_fall > P_PAGE_MAX_NS) flag("page row low");
      if (cas_in_row < 2 && $realtime - ras_fall > `T_RAS_MAX_NS) flag("row low");
      ras_rise = $realtime;
      ras_low = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // column strobe edges
  // ------------------------------------------------------------
  always @(negedge i_col_strobe_n) begin
    if (i_row_strobe_n === 1'b0) begin
      if (cas_in_row > 0 && $realtime - cas_fall < `T_PC_NS) flag("page cycle");
      cas_fall = $realtime;
      cas_in_row++;
      key = {row_q, i_muxed_address_lines};
      if (i_write_strobe_n === 1'b0) begin
        mem[key] = i_shared_data_lines;
      end else begin
        rd_q = 1'b1;
        if (i_host_oe === 1'b1) flag("data contention");
        // late answers stress the controller's sample point
        #(i_slow ? P_SLOW_NS : P_FAST_NS);
        if (i_col_strobe_n === 1'b0) begin
          o_shared_data_lines = mem.exists(key) ? mem[key] : ~key[7:0];
          drive = 1'b1;
        end
      end
    end
  end

  // release shows the inverse, never a value the host could mistake
  always @(posedge i_col_strobe_n) begin
    rd_q = 1'b0;
    if (drive) begin
      drive = 1'b0;
      o_shared_data_lines = ~o_shared_data_lines;
    end
  end

  // write strobe must stay high while a read column is low
  always @(negedge i_write_strobe_n) begin
    if (rd_q) flag("write strobe in read");
  end
endmodule

// ==== testbench/dram_module_strobe_protocol_tb.sv ====
`timescale 1ns/1ps
`include "dram_host_params.svh"

module dram_module_strobe_protocol_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int REF_WIN = 20480; // one refresh every 20 cycles
  localparam int RASP = 40; // shortened page window
  logic sys_clk;
  logic rstn;
  logic req_valid;
  logic req_write;
  logic [`REQ_ADDR_W-1:0] req_addr;
  logic [`DATA_W-1:0] req_wdata;
  logic req_ready;
  logic rd_valid;
  logic [`DATA_W-1:0] rd_data;
  logic ras_only;
  logic slow;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [`ADDR_W-1:0] addr_lines;
  logic [`DATA_W-1:0] ctrl_dq;
  logic [`DATA_W-1:0] mdl_dq;
  logic dq_oe;
  wire [`DATA_W-1:0] dq_wire = dq_oe ? ctrl_dq : mdl_dq; // resolved data lines
  int rev_cnt;
  int row_cnt;
  int violations;
  int errors;
  int samples_checked;
  logic [`DATA_W-1:0] q;

  dram_host_ctrl #(.P_RASP_CYC(RASP), .P_REF_WINDOW_CYC(REF_WIN)) DUT (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_req_valid(req_valid), .i_req_write(req_write),
    .i_req_addr(req_addr), .i_req_wdata(req_wdata), .o_req_ready(req_ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .i_ras_only_refresh(ras_only),
    .o_row_strobe_n(ras_n), .o_col_strobe_n(cas_n), .o_write_strobe_n(we_n),
    .o_muxed_address_lines(addr_lines), .i_shared_data_lines(dq_wire),
    .o_shared_data_lines(ctrl_dq), .o_shared_data_lines_oe(dq_oe));

  dram_module_model #(.P_PAGE_MAX_NS(RASP * 20)) mem_model (
    .i_row_strobe_n(ras_n), .i_col_strobe_n(cas_n), .i_write_strobe_n(we_n),
    .i_muxed_address_lines(addr_lines), .i_shared_data_lines(dq_wire), .i_host_oe(dq_oe),
    .i_slow(slow), .o_shared_data_lines(mdl_dq), .o_rev_count(rev_cnt),
    .o_row_count(row_cnt), .o_violations(violations));

  // ------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // a hang anywhere ends the run through the same verdict
  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // compare and access tasks
  // ------------------------------------------------------------
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_min(input string what, input int lo, input int got);
    samples_checked++;
    if (got < lo) begin
      errors++;
      $display("Error %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask

  // request held until ready; read waits at most six cycles for its answer
  task automatic access(input logic w, input logic [21:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 200);
    chk_byte("request ready", 8'h01, {7'h00, req_ready});
    @(posedge sys_clk);
    req_valid <= 1'b0;
    if (!w) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (rd_valid !== 1'b1 && n < 6);
      chk_byte("read answer", 8'h01, {7'h00, rd_valid});
      q = rd_data;
    end
  endtask

  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // corner rows and columns, written then read back in the given refresh mode
  task automatic t_random(input logic ro, input logic sl);
    logic [21:0] adr [4];
    adr = '{22'h000000, 22'h3fffff, 22'h2aa555, 22'h155aaa};
    ras_only <= ro;
    slow <= sl;
    for (int i = 0; i < 4; i++) access(1'b1, adr[i], adr[i][7:0] ^ 8'h3c);
    for (int i = 0; i < 4; i++) begin
      access(1'b0, adr[i], 8'h00);
      chk_byte("random read", adr[i][7:0] ^ 8'h3c, q);
    end
  endtask

  // same-row writes run as a page until the refresh due every 20 cycles closes it; each read opens the row anew
  task automatic t_page();
    for (int i = 0; i < 10; i++) access(1'b1, {11'h005, 11'(i)}, 8'hc0 + 8'(i));
    for (int i = 0; i < 10; i++) begin
      access(1'b0, {11'h005, 11'(i)}, 8'h00);
      chk_byte("page read", 8'hc0 + 8'(i), q);
    end
  endtask

  // each refresh kind must appear at its pin pattern while idle
  task automatic t_refresh_kind(input logic ro);
    int c0;
    int r0;
    ras_only <= ro;
    @(posedge sys_clk);
    c0 = rev_cnt;
    r0 = row_cnt;
    repeat (200) @(posedge sys_clk);
    if (ro) chk_min("row-only refreshes", r0 + 9, row_cnt);
    else chk_min("reversed refreshes", c0 + 9, rev_cnt);
  endtask

  // a full window must hold every row's refresh
  task automatic t_refresh_rate();
    int total;
    @(negedge sys_clk);
    total = rev_cnt + row_cnt;
    repeat (REF_WIN) @(negedge sys_clk);
    chk_min("refreshes per window", total + `REF_ROWS, rev_cnt + row_cnt);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    samples_checked = 0;
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 22'h000000;
    req_wdata = 8'h00;
    ras_only = 1'b0;
    slow = 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_random(1'b1, 1'b0);
    t_random(1'b0, 1'b1);
    t_page();
    t_refresh_kind(1'b1);
    t_refresh_kind(1'b0);
    t_refresh_rate();
    chk_min("timing clean", 0, -violations);
    tally_and_finish();
  end
endmodule
